// ---- dcs_sequencer.sv ----
// Diskette command sequencer with APB register access
`timescale 1ns/10ps
`default_nettype none
module dcs_sequencer #(
  parameter int unsigned INDEX_LIMIT_CYC = dcs_pkg::INDEX_AVG_CYC
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Host interrupt
  output logic IRQ,
  // Drive pins, asynchronous
  input wire logic [1:0] DOOR_CLOSED,
  input wire logic [1:0] MEDIA_IN,
  input wire logic [1:0] INDEX,
  // Media engine handshake
  output logic MED_REQ,
  output dcs_pkg::dcs_mreq_s MED_CMD,
  input wire logic MED_ACK,
  input wire dcs_pkg::dcs_mres_s MED_RES,
  // DMA master
  output logic DMA_REQ,
  output logic [15:0] DMA_ADDR,
  output logic [15:0] DMA_DATA,
  input wire logic DMA_ACK
);
  import dcs_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_KEY = 4'b0001,
    ST_SECT = 4'b0010,
    ST_TRACK = 4'b0011,
    ST_ADDR = 4'b0100,
    ST_MEDIA = 4'b0101,
    ST_CHECK = 4'b0110,
    ST_IDX1 = 4'b0111,
    ST_IDX2 = 4'b1000,
    ST_DMA = 4'b1001,
    ST_FINISH = 4'b1010
  } dcs_state_e;

  dcs_state_e state_q;
  logic [2:0] func_q;
  logic unit_q, done_q, ie_q, tr_q, den_q, err_q;
  logic [15:0] db_q, es_q;
  logic [7:0] code_q, wc_q, tgt_trk_q, tgt_sec_q;
  logic [7:0] cur_trk_q [2];
  logic [1:0] dden_q;
  logic hl_q;
  logic [1:0] word_q;
  logic [31:0] idx_cnt_q;
  logic [1:0] door_s1, door_s2, media_s1, media_s2, idx_s1, idx_s2;
  logic idx_prev_q;

  // APB decode
  logic apb_setup, apb_wr, mapped;
  assign apb_setup = PSEL && !PENABLE;
  assign apb_wr = PSEL && PENABLE && PREADY && PWRITE && !PSLVERR;
  assign mapped = (PADDR == DCS_OFS_CMD) || (PADDR == DCS_OFS_DATA) ||
                  (PADDR == DCS_OFS_ERR);
  logic wr_cmd, wr_data;
  assign wr_cmd = apb_wr && (PADDR == DCS_OFS_CMD);
  assign wr_data = apb_wr && (PADDR == DCS_OFS_DATA);

  logic [15:0] cs_view;
  assign cs_view = {err_q, 6'h00, den_q, tr_q, ie_q, done_q, unit_q,
                    func_q, 1'b0};

  // Answer one cycle after setup, so read data comes from a flop
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h0000_0000;
    end else begin
      PREADY <= apb_setup;
      PSLVERR <= apb_setup && !mapped;
      if (apb_setup && !PWRITE) begin
        unique case (PADDR)
          DCS_OFS_CMD: PRDATA <= {16'h0000, cs_view};
          DCS_OFS_DATA: PRDATA <= {16'h0000, db_q};
          DCS_OFS_ERR: PRDATA <= {16'h0000, es_q};
          default: PRDATA <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Drive pins pass two flops before use
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      door_s1 <= 2'h0;
      door_s2 <= 2'h0;
      media_s1 <= 2'h0;
      media_s2 <= 2'h0;
      idx_s1 <= 2'h0;
      idx_s2 <= 2'h0;
      idx_prev_q <= 1'b0;
    end else begin
      door_s1 <= DOOR_CLOSED;
      door_s2 <= door_s1;
      media_s1 <= MEDIA_IN;
      media_s2 <= media_s1;
      idx_s1 <= INDEX;
      idx_s2 <= idx_s1;
      idx_prev_q <= idx_s2[unit_q];
    end
  end

  logic idx_rise;
  assign idx_rise = idx_s2[unit_q] && !idx_prev_q;

  // Positioning and data results, first fault wins
  function automatic logic [7:0] fault_code(input dcs_mres_s r);
    if (r.trk0_early) return EC_TRK0_EARLY;
    if (r.trk_mism) return EC_TRK_MISM;
    if (r.no_sect) return EC_NO_SECT;
    if (r.crc_err) return EC_DATA_CRC;
    return EC_NONE;
  endfunction

  // Word that follows the one on the bus now
  logic [1:0] word_nx;
  logic [15:0] ext_word;
  assign word_nx = word_q + 2'h1;
  always_comb begin
    unique case (word_nx)
      2'h0: ext_word = {wc_q, code_q};
      2'h1: ext_word = {cur_trk_q[1], cur_trk_q[0]};
      2'h2: ext_word = {tgt_sec_q, tgt_trk_q};
      default: ext_word = {cur_trk_q[unit_q], unit_q, dden_q[1], hl_q,
                           dden_q[0], 3'h0, den_q};
    endcase
  end

  // Command sequencing and register state
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_q <= ST_IDLE;
      func_q <= 3'h0;
      unit_q <= 1'b0;
      done_q <= 1'b1;
      ie_q <= 1'b0;
      tr_q <= 1'b0;
      den_q <= 1'b0;
      err_q <= 1'b0;
      db_q <= 16'h0000;
      es_q <= 16'h0000;
      code_q <= EC_NONE;
      wc_q <= 8'h00;
      tgt_trk_q <= 8'h00;
      tgt_sec_q <= 8'h00;
      cur_trk_q[0] <= 8'h00;
      cur_trk_q[1] <= 8'h00;
      dden_q <= 2'h0;
      hl_q <= 1'b0;
      word_q <= 2'h0;
      idx_cnt_q <= 32'h0000_0000;
      MED_REQ <= 1'b0;
      MED_CMD <= '0;
      DMA_REQ <= 1'b0;
      DMA_ADDR <= 16'h0000;
      DMA_DATA <= 16'h0000;
    end else begin
      if (wr_cmd) ie_q <= PWDATA[CS_IE];
      if (wr_cmd && PWDATA[CS_INIT]) begin
        // Initialise overrides everything, aborting any transfer
        state_q <= ST_IDLE;
        tr_q <= 1'b0;
        err_q <= 1'b0;
        MED_REQ <= 1'b0;
        DMA_REQ <= 1'b0;
        cur_trk_q[0] <= 8'h00;
        cur_trk_q[1] <= 8'h00;
        hl_q <= 1'b0;
        code_q <= EC_NONE;
        es_q <= 16'h0000;
        es_q[ES_INIT_DONE] <= 1'b1;
        done_q <= 1'b1;
      end else begin
        unique case (state_q)
          ST_IDLE: begin
            if (wr_cmd && PWDATA[CS_GO]) begin
              func_q <= PWDATA[CS_FUNC_LO +: 3];
              unit_q <= PWDATA[CS_UNIT];
              den_q <= PWDATA[CS_DEN];
              done_q <= 1'b0;
              err_q <= 1'b0;
              // Retrieval must still report the previous command's code
              if (PWDATA[CS_FUNC_LO +: 3] != FN_EXT_ST) begin
                code_q <= EC_NONE;
              end
              unique case (PWDATA[CS_FUNC_LO +: 3])
                FN_SET_DEN: begin
                  es_q <= 16'h0000;
                  tr_q <= 1'b1;
                  state_q <= ST_KEY;
                end
                FN_WR_DEL: begin
                  es_q <= 16'h0000;
                  tr_q <= 1'b1;
                  state_q <= ST_SECT;
                end
                FN_STATUS: begin
                  es_q[ES_DRV_RDY] <= 1'b0;
                  state_q <= ST_CHECK;
                end
                FN_EXT_ST: begin
                  tr_q <= 1'b1;
                  state_q <= ST_ADDR;
                end
                // Buffer and plain sector functions live elsewhere
                default: state_q <= ST_FINISH;
              endcase
            end
          end
          ST_KEY: begin
            if (wr_data) begin
              tr_q <= 1'b0;
              if (PWDATA[7:0] == KEY_BYTE) begin
                tgt_trk_q <= 8'h00;
                tgt_sec_q <= FIRST_SECT;
                MED_CMD <= '{op: MOP_SEEK, unit: unit_q, track: 8'h00,
                             sector: FIRST_SECT, dbl_den: den_q,
                             deleted: 1'b0, zero_fill: 1'b1};
                MED_REQ <= 1'b1;
                state_q <= ST_MEDIA;
              end else begin
                code_q <= EC_BAD_KEY;
                err_q <= 1'b1;
                state_q <= ST_FINISH;
              end
            end
          end
          ST_SECT: begin
            if (wr_data) begin
              tr_q <= 1'b0;
              tgt_sec_q <= PWDATA[7:0];
              state_q <= ST_TRACK;
            end
          end
          ST_TRACK: begin
            // Request flag drops on the host write of the track
            if (wr_data) begin
              tr_q <= 1'b0;
              tgt_trk_q <= PWDATA[7:0];
              if (PWDATA[7:0] > LAST_TRACK) begin
                code_q <= EC_BAD_TRK;
                err_q <= 1'b1;
                state_q <= ST_FINISH;
              end else begin
                MED_CMD <= '{op: MOP_SEEK, unit: unit_q, track: PWDATA[7:0],
                             sector: tgt_sec_q, dbl_den: den_q,
                             deleted: 1'b1, zero_fill: 1'b0};
                MED_REQ <= 1'b1;
                state_q <= ST_MEDIA;
              end
            end else if (!tr_q) begin
              tr_q <= 1'b1;
            end
          end
          ST_ADDR: begin
            if (wr_data) begin
              tr_q <= 1'b0;
              DMA_ADDR <= PWDATA[15:0];
              DMA_DATA <= {wc_q, code_q};
              DMA_REQ <= 1'b1;
              word_q <= 2'h0;
              state_q <= ST_DMA;
            end
          end
          ST_DMA: begin
            if (DMA_ACK) begin
              if (word_q == EXT_LAST_WORD) begin
                DMA_REQ <= 1'b0;
                state_q <= ST_FINISH;
              end else begin
                word_q <= word_q + 2'h1;
                DMA_ADDR <= DMA_ADDR + DMA_STEP;
                DMA_DATA <= ext_word;
              end
            end
          end
          ST_CHECK: begin
            idx_cnt_q <= 32'h0000_0000;
            if (door_s2[unit_q] && media_s2[unit_q]) state_q <= ST_IDX1;
            else state_q <= ST_FINISH;
          end
          ST_IDX1: begin
            idx_cnt_q <= idx_cnt_q + 32'h1;
            if (idx_rise) begin
              idx_cnt_q <= 32'h0000_0000;
              state_q <= ST_IDX2;
            end else if (idx_cnt_q >= INDEX_LIMIT_CYC) begin
              state_q <= ST_FINISH;
            end
          end
          ST_IDX2: begin
            idx_cnt_q <= idx_cnt_q + 32'h1;
            if (idx_rise) begin
              // Spinning at speed: interval inside the limit
              es_q[ES_DRV_RDY] <= 1'b1;
              hl_q <= 1'b1;
              MED_CMD <= '{op: MOP_READ, unit: unit_q,
                           track: cur_trk_q[unit_q], sector: 8'h00,
                           dbl_den: den_q, deleted: 1'b0,
                           zero_fill: 1'b0};
              MED_REQ <= 1'b1;
              state_q <= ST_MEDIA;
            end else if (idx_cnt_q >= INDEX_LIMIT_CYC) begin
              state_q <= ST_FINISH;
            end
          end
          ST_MEDIA: begin
            if (MED_ACK) begin
              MED_REQ <= 1'b0;
              hl_q <= 1'b1;
              unique case (MED_CMD.op)
                MOP_READ: begin
                  es_q[ES_DRIVE_DENSITY_BIT] <= MED_RES.dd_mark;
                  dden_q[unit_q] <= MED_RES.dd_mark;
                  es_q[ES_FMT_LO +: 3] <= MED_RES.fmt;
                  if (MED_RES.del_mark) es_q[ES_DEL] <= 1'b1;
                  if (MED_RES.crc_err) begin
                    es_q[ES_CRC] <= 1'b1;
                    code_q <= EC_DATA_CRC;
                    err_q <= 1'b1;
                  end
                  state_q <= ST_FINISH;
                end
                MOP_SEEK: begin
                  if (fault_code(MED_RES) != EC_NONE) begin
                    code_q <= fault_code(MED_RES);
                    err_q <= 1'b1;
                    state_q <= ST_FINISH;
                  end else begin
                    cur_trk_q[unit_q] <= MED_CMD.track;
                    MED_CMD.op <= MOP_WRITE;
                    MED_REQ <= 1'b1;
                  end
                end
                default: begin
                  if (MED_CMD.zero_fill) begin
                    if (MED_RES.bad_hdr) begin
                      err_q <= 1'b1;
                      state_q <= ST_FINISH;
                    end else if (tgt_sec_q != LAST_SECT) begin
                      tgt_sec_q <= tgt_sec_q + 8'h01;
                      MED_CMD.sector <= tgt_sec_q + 8'h01;
                      MED_REQ <= 1'b1;
                    end else if (tgt_trk_q != LAST_TRACK) begin
                      tgt_sec_q <= FIRST_SECT;
                      tgt_trk_q <= tgt_trk_q + 8'h01;
                      MED_CMD.op <= MOP_SEEK;
                      MED_CMD.track <= tgt_trk_q + 8'h01;
                      MED_CMD.sector <= FIRST_SECT;
                      MED_REQ <= 1'b1;
                    end else begin
                      dden_q[unit_q] <= den_q;
                      state_q <= ST_FINISH;
                    end
                  end else begin
                    if (fault_code(MED_RES) != EC_NONE) begin
                      code_q <= fault_code(MED_RES);
                      err_q <= 1'b1;
                    end
                    state_q <= ST_FINISH;
                  end
                end
              endcase
            end
          end
          ST_FINISH: begin
            db_q <= es_q;
            done_q <= 1'b1;
            state_q <= ST_IDLE;
          end
          default: state_q <= ST_IDLE;
        endcase
      end
    end
  end

  // Request follows enable and done together
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) IRQ <= 1'b0;
    else IRQ <= ie_q && done_q;
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);

  a_key_wrong_code: assert property (
    (state_q == ST_KEY && wr_data && PWDATA[7:0] != KEY_BYTE && !wr_cmd)
    |=> code_q == EC_BAD_KEY && err_q ##1 done_q && !MED_REQ)
    else $error("wrong key did not end with code 250");
  a_key_ok_seek: assert property (
    (state_q == ST_KEY && wr_data && PWDATA[7:0] == KEY_BYTE && !wr_cmd)
    |=> MED_REQ && MED_CMD.op == MOP_SEEK && MED_CMD.track == 8'h00
        && MED_CMD.sector == FIRST_SECT)
    else $error("valid key did not seek track 0 sector 1");
  a_init_no_header: assert property (
    MED_REQ && MED_CMD.zero_fill |-> MED_CMD.op != MOP_READ
      && MED_CMD.sector >= FIRST_SECT && MED_CMD.sector <= LAST_SECT)
    else $error("density init issued an illegal media step");
  a_start_clears_done: assert property (
    (state_q == ST_IDLE && wr_cmd && PWDATA[CS_GO] && !PWDATA[CS_INIT])
    |=> !done_q && code_q == (($past(PWDATA[CS_FUNC_LO +: 3]) == FN_EXT_ST) ?
                              $past(code_q) : EC_NONE))
    else $error("new command left done or code set");
  a_irq_follows: assert property (
    (ie_q && done_q) |=> IRQ)
    else $error("interrupt missing with enable and done");
  a_status_copy: assert property (
    state_q == ST_FINISH && !wr_cmd |=> db_q == $past(es_q) && done_q)
    else $error("status not copied to data buffer at finish");
  a_bad_track: assert property (
    (state_q == ST_TRACK && wr_data && !wr_cmd && PWDATA[7:0] > LAST_TRACK)
    |=> code_q == EC_BAD_TRK ##1 done_q && err_q)
    else $error("track above 76 not reported as 040");
  a_ext_four_words: assert property (
    (state_q == ST_DMA && DMA_ACK && word_q == EXT_LAST_WORD && !wr_cmd)
    |=> !DMA_REQ ##1 done_q)
    else $error("extended status did not finish after four words");
  a_dd_mark_bit: assert property (
    (state_q == ST_MEDIA && MED_ACK && MED_CMD.op == MOP_READ && !wr_cmd)
    |=> es_q[ES_DRIVE_DENSITY_BIT] == $past(MED_RES.dd_mark))
    else $error("drive density bit does not follow mark");
endmodule : dcs_sequencer
`default_nettype wire

// ---- dcs_pkg.sv ----
// Shared constants and carrier types for the diskette command sequencer
package dcs_pkg;
  // Register byte offsets on APB
  localparam logic [11:0] DCS_OFS_CMD = 12'h000;
  localparam logic [11:0] DCS_OFS_DATA = 12'h004;
  localparam logic [11:0] DCS_OFS_ERR = 12'h008;
  // Command/status fields
  localparam int CS_GO = 0;
  localparam int CS_FUNC_LO = 1;
  localparam int CS_UNIT = 4;
  localparam int CS_DONE = 5;
  localparam int CS_IE = 6;
  localparam int CS_TR = 7;
  localparam int CS_DEN = 8;
  localparam int CS_INIT = 14;
  localparam int CS_ERR = 15;
  // Error/status fields
  localparam int ES_CRC = 0;
  localparam int ES_INIT_DONE = 2;
  localparam int ES_DRIVE_DENSITY_BIT = 5;
  localparam int ES_DEL = 6;
  localparam int ES_DRV_RDY = 7;
  localparam int ES_FMT_LO = 13;
  // Function codes
  localparam logic [2:0] FN_SET_DEN = 3'h4;
  localparam logic [2:0] FN_STATUS = 3'h5;
  localparam logic [2:0] FN_WR_DEL = 3'h6;
  localparam logic [2:0] FN_EXT_ST = 3'h7;
  // Key byte and definitive error codes
  localparam logic [7:0] KEY_BYTE = 8'h49;
  localparam logic [7:0] EC_NONE = 8'h00;
  localparam logic [7:0] EC_BAD_TRK = 8'h20;
  localparam logic [7:0] EC_TRK0_EARLY = 8'h28;
  localparam logic [7:0] EC_NO_SECT = 8'h38;
  localparam logic [7:0] EC_TRK_MISM = 8'h68;
  localparam logic [7:0] EC_DATA_CRC = 8'h80;
  localparam logic [7:0] EC_BAD_KEY = 8'hA8;
  // Geometry and extended status transfer
  localparam logic [7:0] LAST_TRACK = 8'h4C;
  localparam logic [7:0] FIRST_SECT = 8'h01;
  localparam logic [7:0] LAST_SECT = 8'h1A;
  localparam logic [1:0] EXT_LAST_WORD = 2'h3;
  localparam logic [15:0] DMA_STEP = 16'h0002;
  // Speed check timing
  localparam int CLK_MHZ = 100;
  localparam int INDEX_AVG_MS = 250;
  localparam int INDEX_AVG_CYC = INDEX_AVG_MS * 1000 * CLK_MHZ;

  typedef enum logic [1:0] {
    MOP_SEEK = 2'b00,
    MOP_WRITE = 2'b01,
    MOP_READ = 2'b10
  } dcs_mop_e;

  typedef struct packed {
    dcs_mop_e op;
    logic unit;
    logic [7:0] track;
    logic [7:0] sector;
    logic dbl_den;
    logic deleted;
    logic zero_fill;
  } dcs_mreq_s;

  typedef struct packed {
    logic bad_hdr;
    logic no_sect;
    logic trk_mism;
    logic trk0_early;
    logic dd_mark;
    logic del_mark;
    logic crc_err;
    logic [2:0] fmt;
  } dcs_mres_s;
endpackage : dcs_pkg

// ---- dcs_far_model.sv ----
// Far-side model: media engine, DMA memory and drive index pulses
`timescale 1ns/10ps
`default_nettype none
module dcs_far_model import dcs_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Media engine
  input wire logic med_req,
  input wire dcs_pkg::dcs_mreq_s med_cmd,
  output logic med_ack,
  output dcs_pkg::dcs_mres_s med_res,
  // DMA memory
  input wire logic dma_req,
  input wire logic [15:0] dma_addr,
  input wire logic [15:0] dma_data,
  output logic dma_ack,
  // Drive pins and bench controls
  output logic [1:0] index,
  input wire logic [31:0] bad_at,
  input wire dcs_pkg::dcs_mres_s res_cfg
);
  int n_wr, n_seek, n_rd, n_dma, tick;
  dcs_mreq_s last;
  logic [15:0] w[4];
  logic [15:0] a[4];
  logic [1:0] dly;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      {med_ack, dma_ack, index, dly, med_res, last} <= '0;
      {n_wr, n_seek, n_rd, n_dma, tick} <= '0;
    end else begin
      med_ack <= 1'b0;
      dma_ack <= 1'b0;
      dly <= dly + 2'h1;
      tick <= (tick == 99) ? 0 : tick + 1;
      index <= (tick == 0) ? 2'h3 : 2'h0;
      // Varying delay gives both prompt and slow answers
      if (med_req && !med_ack && dly == 2'h0) begin
        med_ack <= 1'b1;
        last <= med_cmd;
        med_res <= res_cfg;
        med_res.bad_hdr <= med_cmd.op == MOP_WRITE && n_wr + 1 == bad_at;
        if (med_cmd.op == MOP_WRITE) n_wr <= n_wr + 1;
        if (med_cmd.op == MOP_SEEK) n_seek <= n_seek + 1;
        if (med_cmd.op == MOP_READ) n_rd <= n_rd + 1;
      end else begin
        // Result lines carry no valid value outside the answer
        med_res <= ~med_res;
      end
      if (dma_req && !dma_ack && dly[0]) begin
        dma_ack <= 1'b1;
        w[n_dma % 4] <= dma_data;
        a[n_dma % 4] <= dma_addr;
        n_dma <= n_dma + 1;
      end
    end
  end
endmodule : dcs_far_model
`default_nettype wire

// ---- tb_diskette_cmd_status_sequencer.sv ----
// Self-checking testbench for the diskette command sequencer
`timescale 1ns/10ps
`default_nettype none
module tb_diskette_cmd_status_sequencer;
  import dcs_pkg::*;
  logic clk, rstn, psel, penable, pwrite, pready, pslverr, irq, err_q;
  logic med_req, med_ack, dma_req, dma_ack;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_q, bad_at;
  logic [1:0] door, media, index;
  logic [15:0] dma_addr, dma_data;
  dcs_mreq_s med_cmd;
  dcs_mres_s med_res, res_cfg;
  int miscompares, n_checks, w0, s0, r0;
  dcs_sequencer #(.INDEX_LIMIT_CYC(200)) u_dcs_sequencer (.CLK(clk),
    .RSTN(rstn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .IRQ(irq), .DOOR_CLOSED(door), .MEDIA_IN(media),
    .INDEX(index), .MED_REQ(med_req), .MED_CMD(med_cmd),
    .MED_ACK(med_ack), .MED_RES(med_res), .DMA_REQ(dma_req),
    .DMA_ADDR(dma_addr), .DMA_DATA(dma_data), .DMA_ACK(dma_ack));
  dcs_far_model u_dcs_far_model (.clk(clk), .rstn(rstn),
    .med_req(med_req), .med_cmd(med_cmd), .med_ack(med_ack),
    .med_res(med_res), .dma_req(dma_req), .dma_addr(dma_addr),
    .dma_data(dma_data), .dma_ack(dma_ack), .index(index),
    .bad_at(bad_at), .res_cfg(res_cfg));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task summarize;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wait_cs(input int b, input logic v);
    int i;
    for (i = 0; i < 5000; i++) begin
      apb(1'b0, DCS_OFS_CMD, 32'h0);
      if (rd_q[b] === v) return;
    end
    miscompares++;
    $display("unexpected at %0t: flag wait ran out", $time);
    summarize;
  endtask : wait_cs
  task cmd(input logic [2:0] fn, input logic u, input logic den);
    apb(1'b1, DCS_OFS_CMD, {23'h0, den, 3'h2, u, fn, 1'b1});
  endtask : cmd
  task key_cmd(input logic den, input logic [7:0] k);
    w0 = u_dcs_far_model.n_wr;
    s0 = u_dcs_far_model.n_seek;
    r0 = u_dcs_far_model.n_rd;
    cmd(FN_SET_DEN, 1'b0, den);
    wait_cs(CS_TR, 1'b1);
    apb(1'b1, DCS_OFS_DATA, {24'h0, k});
    wait_cs(CS_DONE, 1'b1);
  endtask : key_cmd
  task t_bad_key;
    key_cmd(1'b0, 8'h48);
    chk(rd_q[CS_ERR], 1'b1, "error after wrong key");
    chk(u_dcs_far_model.n_wr - w0, 0, "wrote on wrong key");
    $display("test done: bad key");
  endtask : t_bad_key
  task t_ext(input logic [7:0] code);
    cmd(FN_EXT_ST, 1'b1, 1'b1);
    wait_cs(CS_TR, 1'b1);
    apb(1'b1, DCS_OFS_DATA, 32'h0200);
    wait_cs(CS_DONE, 1'b1);
    chk(u_dcs_far_model.w[0][7:0], code, "error code");
    chk(u_dcs_far_model.a[0], 16'h0200, "first address");
    chk(u_dcs_far_model.a[3], 16'h0206, "last address");
    chk(u_dcs_far_model.w[3][0], 1'b1, "command density");
    chk(u_dcs_far_model.w[3][7], 1'b1, "unit select");
    $display("test done: extended status");
  endtask : t_ext
  task t_init;
    key_cmd(1'b1, KEY_BYTE);
    chk(rd_q[CS_ERR], 1'b0, "error on good init");
    chk(u_dcs_far_model.n_wr - w0, 2002, "sector writes");
    chk(u_dcs_far_model.n_seek - s0, 77, "track seeks");
    chk(u_dcs_far_model.n_rd - r0, 0, "header access");
    chk(u_dcs_far_model.last.track, 76, "last track");
    chk(u_dcs_far_model.last.sector, 26, "last sector");
    chk(u_dcs_far_model.last.dbl_den, 1'b1, "density");
    chk(u_dcs_far_model.last.zero_fill, 1'b1, "zero fill");
    $display("test done: density init");
  endtask : t_init
  task t_bad_hdr;
    bad_at <= u_dcs_far_model.n_wr + 5;
    key_cmd(1'b0, KEY_BYTE);
    chk(rd_q[CS_ERR], 1'b1, "error on bad header");
    chk(u_dcs_far_model.n_wr - w0, 5, "writes after bad header");
    bad_at <= 32'h0;
    $display("test done: bad header");
  endtask : t_bad_hdr
  task t_del(input logic [7:0] trk);
    s0 = u_dcs_far_model.n_seek;
    cmd(FN_WR_DEL, 1'b0, 1'b1);
    wait_cs(CS_TR, 1'b1);
    apb(1'b1, DCS_OFS_DATA, 32'h3);
    wait_cs(CS_TR, 1'b1);
    apb(1'b1, DCS_OFS_DATA, {24'h0, trk});
    wait_cs(CS_DONE, 1'b1);
    chk(rd_q[CS_ERR], trk > LAST_TRACK, "track range error");
    chk(u_dcs_far_model.n_seek - s0, trk <= LAST_TRACK, "seeks");
    chk(u_dcs_far_model.last.dbl_den, 1'b1, "deleted density");
    chk(u_dcs_far_model.last.deleted, 1'b1, "deleted mark");
    chk(u_dcs_far_model.last.sector, 3, "deleted sector");
    chk(u_dcs_far_model.last.track, 2, "deleted track");
    $display("test done: deleted write");
  endtask : t_del
  task t_status;
    dcs_mres_s rc;
    int i;
    for (i = 0; i < 3; i++) begin
      rc = '0;
      rc.dd_mark = i[0];
      rc.del_mark = i != 0;
      rc.crc_err = i[1];
      rc.fmt = 3'h5;
      res_cfg <= rc;
      cmd(FN_STATUS, 1'b1, 1'b0);
      wait_cs(CS_DONE, 1'b1);
      chk(rd_q[CS_ERR], i[1], "crc error flag");
      apb(1'b0, DCS_OFS_DATA, 32'h0);
      chk(rd_q[ES_DRV_RDY], 1'b1, "drive ready");
      chk(rd_q[ES_DRIVE_DENSITY_BIT], i[0], "drive density");
      chk(rd_q[ES_DEL], i != 0, "deleted flag");
      chk(rd_q[ES_CRC], i[1], "data crc bit");
      chk(rd_q[15:13], 3'h5, "format code");
      chk(u_dcs_far_model.last.unit, 1'b1, "query unit");
      chk(irq, 1'b1, "interrupt");
    end
    t_ext(EC_DATA_CRC);
    media <= 2'h1;
    r0 = u_dcs_far_model.n_rd;
    cmd(FN_STATUS, 1'b1, 1'b0);
    wait_cs(CS_DONE, 1'b1);
    apb(1'b0, DCS_OFS_DATA, 32'h0);
    chk(rd_q[ES_DRV_RDY], 1'b0, "no media ready");
    chk(u_dcs_far_model.n_rd - r0, 0, "read without media");
    $display("test done: status query");
  endtask : t_status
  initial begin
    {rstn, psel, penable, pwrite, paddr, pwdata, bad_at, res_cfg} = '0;
    door = 2'h3;
    media = 2'h3;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    apb(1'b0, 12'h00C, 32'h0);
    chk(err_q, 1'b1, "unmapped error");
    chk(rd_q, 32'h0, "unmapped data");
    t_bad_key;
    t_ext(EC_BAD_KEY);
    t_init;
    t_ext(EC_NONE);
    t_bad_hdr;
    t_del(8'h02);
    t_del(8'h4D);
    t_ext(EC_BAD_TRK);
    t_status;
    summarize;
  end
  // Cuts a hang short; the full run needs about a tenth of this span
  initial begin
    #1000000;
    miscompares++;
    summarize;
  end
endmodule : tb_diskette_cmd_status_sequencer
`default_nettype wire
